// file: hdl/fop_top.sv
`include "fop_consts.svh"
`default_nettype none
module fop_top
	import fop_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// normal control from the floppy controller core
	input  wire logic                  densNormal,
	input  wire logic                  driveSel0,
	input  wire logic                  driveSel1,
	input  wire logic                  motorEn0,
	input  wire logic                  motorEn1,
	input  wire logic [`FOP_AUX_W-1:0] auxOut,
	// dedicated floppy pads
	output logic      [`FOP_PIN_W-1:0] floppyPinOut,
	output logic      [`FOP_PIN_W-1:0] floppyPinOe,
	// floppy signals routed to the parallel port pads
	output logic      [`FOP_PIN_W-1:0] ppFloppyLevel,
	// interface mode to the controller core
	output logic      [1:0]            ifModeSel
);
	logic                  wrEn;
	logic [`FOP_IDX_W-1:0] wrIdx;
	logic [7:0]            wrData;
	logic [7:0]            rdOpt;
	logic [7:0]            rdMode;

	fop_dens_t             dens_reg;
	fop_ifmode_t           ifMode_reg;
	logic                  swap_reg;
	logic                  pushPull_reg;
	logic                  triState_reg;

	logic                  densLevel;
	logic [`FOP_PIN_W-1:0] level;
	logic [`FOP_PIN_W-1:0] ppLevel_reg;

	logic                  optWr;
	logic                  modeWr;

	// bus slave: decodes, forwards and returns read data
	fop_ahb_slave u_bus
	(
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wrEn      (wrEn),
		.wrIdx     (wrIdx),
		.wrData    (wrData),
		.rdOpt     (rdOpt),
		.rdMode    (rdMode)
	);

	assign optWr  = wrEn && wrIdx == `FOP_OPT_IDX;
	assign modeWr = wrEn && wrIdx == `FOP_MODE_IDX;

	// option register: only the density field is stored
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			dens_reg <= fop_dens_t'(2'(`FOP_OPT_RST >> `FOP_DENS_LSB));
		else if (optWr)
			dens_reg <= fop_dens_t'(wrData[`FOP_DENS_MSB:`FOP_DENS_LSB]);

	// mode register; reserved bit 5 is neither stored nor read back
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			ifMode_reg   <= FOP_MD_AT;
			swap_reg     <= 1'b0;
			pushPull_reg <= 1'b0;
			triState_reg <= 1'b0;
		end
		else if (modeWr)
		begin
			ifMode_reg   <= fop_ifmode_t'(wrData[`FOP_IFM_MSB:`FOP_IFM_LSB]);
			swap_reg     <= wrData[`FOP_SWAP_BIT];
			pushPull_reg <= wrData[`FOP_TYPE_BIT];
			triState_reg <= wrData[`FOP_TRI_BIT];
		end

	// read-back views; unimplemented bits read as zero
	always_comb
	begin
		rdOpt = 8'h00;
		rdOpt[`FOP_DENS_MSB:`FOP_DENS_LSB] = dens_reg;
		rdMode = 8'h00;
		rdMode[`FOP_IFM_MSB:`FOP_IFM_LSB] = ifMode_reg;
		rdMode[`FOP_SWAP_BIT] = swap_reg;
		rdMode[`FOP_TYPE_BIT] = pushPull_reg;
		rdMode[`FOP_TRI_BIT]  = triState_reg;
	end

	// density override; the user code behaves like normal
	always_comb
	begin
		unique case (dens_reg)
			FOP_DNS_NORM: densLevel = densNormal;
			FOP_DNS_USER: densLevel = densNormal;
			FOP_DNS_HIGH: densLevel = 1'b1;
			FOP_DNS_LOW:  densLevel = 1'b0;
		endcase
	end

	// output vector with optional drive and motor swap
	always_comb
	begin
		level = '0;
		level[`FOP_P_DENS] = densLevel;
		level[`FOP_P_DS0]  = swap_reg ? driveSel1 : driveSel0;
		level[`FOP_P_DS1]  = swap_reg ? driveSel0 : driveSel1;
		level[`FOP_P_MOT0] = swap_reg ? motorEn1 : motorEn0;
		level[`FOP_P_MOT1] = swap_reg ? motorEn0 : motorEn1;
		level[`FOP_PIN_W-1:`FOP_P_AUX] = auxOut;
	end

	// dedicated pads follow driver type and tri-state control
	fop_pin_drive #(.W(`FOP_PIN_W)) u_pads
	(
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.level    (level),
		.pushPull (pushPull_reg),
		.triState (triState_reg),
		.pinOut   (floppyPinOut),
		.pinOe    (floppyPinOe)
	);

	// parallel path sees the levels but never the pad setup,
	// so type and tri-state bits cannot disturb it
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			ppLevel_reg <= '0;
		else
			ppLevel_reg <= level;

	assign ppFloppyLevel = ppLevel_reg;

	// mode select registered once more to keep outputs on flops
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			ifModeSel <= `FOP_IFM_AT;
		else
			ifModeSel <= ifMode_reg;

	// checks, all on the system clock
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	logic rstSeen_reg;
	logic rdTake;

	// marks the first edge after reset release
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			rstSeen_reg <= 1'b0;
		else
			rstSeen_reg <= 1'b1;

	// a read address phase taken on this edge
	assign rdTake = hsel && hready &&
		htrans == `FOP_HTRANS_NSEQ && !hwrite;

	// normal and user codes pass the core level through
	dens_normal_a: assert property (
		!dens_reg[1] |=> ppFloppyLevel[`FOP_P_DENS] == $past(densNormal))
		else $error("density not following normal control");

	// the user code on its own, as software may choose it
	user_code_a: assert property (
		dens_reg == FOP_DNS_USER |=>
			ppFloppyLevel[`FOP_P_DENS] == $past(densNormal))
		else $error("user density code not normal");

	// forced codes override whatever the core drives
	dens_high_a: assert property (
		dens_reg == FOP_DNS_HIGH |=> ppFloppyLevel[`FOP_P_DENS])
		else $error("density not forced high");

	// a low level must win even with the core driving high
	dens_low_a: assert property (
		dens_reg == FOP_DNS_LOW |=> !ppFloppyLevel[`FOP_P_DENS])
		else $error("density not forced low");

	// first edge after release still shows the reset state
	reset_value_a: assert property (
		!rstSeen_reg |-> rdOpt == `FOP_OPT_RST &&
			dens_reg == FOP_DNS_NORM)
		else $error("option register not zero after reset");

	// the core leaves reset in the default interface mode
	mode_reset_a: assert property (
		!rstSeen_reg |-> ifModeSel == `FOP_IFM_AT &&
			ifMode_reg == FOP_MD_AT)
		else $error("interface mode not default after reset");

	// swap exchanges both pairs of selects
	swap_sel_a: assert property (
		swap_reg |=> ppFloppyLevel[`FOP_P_DS0] == $past(driveSel1) &&
			ppFloppyLevel[`FOP_P_DS1] == $past(driveSel0) &&
			ppFloppyLevel[`FOP_P_MOT0] == $past(motorEn1) &&
			ppFloppyLevel[`FOP_P_MOT1] == $past(motorEn0))
		else $error("drive or motor select swap wrong");

	// without swap drive select 0 and motor enable 1 stay where they are
	no_swap_a: assert property (
		!swap_reg |=> ppFloppyLevel[`FOP_P_DS0] == $past(driveSel0) &&
			ppFloppyLevel[`FOP_P_MOT1] == $past(motorEn1))
		else $error("selects exchanged without swap");

	// pads use the setup of the edge before, so the type is taken
	// one cycle back; a mode write may change it in between
	drive_type_a: assert property (
		!triState_reg |=> $past(pushPull_reg) ?
			(floppyPinOe == '1 && floppyPinOut == ppFloppyLevel) :
			(floppyPinOut == '0 && floppyPinOe == ~ppFloppyLevel))
		else $error("pad driver type wrong");

	// open drain must never push a high level out
	open_drain_a: assert property (
		!pushPull_reg |=> floppyPinOut == '0)
		else $error("open drain pad driving high");

	// push-pull drives every pad while not tri-stated
	push_pull_a: assert property (
		pushPull_reg && !triState_reg |=> floppyPinOe == '1)
		else $error("push-pull pad not driven");

	// tri-state wins over both driver types
	tri_state_a: assert property (
		triState_reg |=> floppyPinOe == '0)
		else $error("pads driven while tri-stated");

	// parallel aux levels ignore the pad setup entirely
	pp_path_a: assert property (
		(triState_reg || pushPull_reg) |=>
			ppFloppyLevel[`FOP_PIN_W-1:`FOP_P_AUX] == $past(auxOut))
		else $error("parallel path disturbed by pad setup");

	// the whole vector, swap and density included, still passes
	pp_level_a: assert property (
		triState_reg || pushPull_reg |=> ppFloppyLevel == $past(level))
		else $error("parallel levels changed by pad setup");

	// mode field reaches the core two edges after the write
	mode_field_a: assert property (
		modeWr |=> ##1 ifModeSel ==
			$past(wrData[`FOP_IFM_MSB:`FOP_IFM_LSB], 2))
		else $error("interface mode not taken from write");

	// read data stands the cycle after the address phase
	read_back_a: assert property (
		hsel && hready && htrans == `FOP_HTRANS_NSEQ && !hwrite &&
		haddr == {`FOP_ADDR_PAD, `FOP_MODE_IDX, 2'h0} && !wrEn
		|=> hrdata == {`FOP_DATA_PAD, $past(rdMode)})
		else $error("mode register read back wrong");

	// same for the option word, density field only
	opt_read_a: assert property (
		rdTake && haddr == {`FOP_ADDR_PAD, `FOP_OPT_IDX, 2'h0} && !wrEn
		|=> hrdata == {`FOP_DATA_PAD, $past(rdOpt)})
		else $error("option register read back wrong");

	// reads outside the two register words return zero
	unmapped_read_a: assert property (
		rdTake && haddr[31:2] != {`FOP_ADDR_PAD, `FOP_OPT_IDX} &&
		haddr[31:2] != {`FOP_ADDR_PAD, `FOP_MODE_IDX}
		|=> hrdata == '0)
		else $error("unmapped read not zero");

	// a density write shows on the outputs two edges later
	write_effect_a: assert property (
		optWr && wrData[`FOP_DENS_MSB:`FOP_DENS_LSB] == `FOP_DENS_HIGH
		|=> ##1 ppFloppyLevel[`FOP_P_DENS])
		else $error("density write late on outputs");

	// the low code takes effect just as fast
	write_low_a: assert property (
		optWr && wrData[`FOP_DENS_MSB:`FOP_DENS_LSB] == `FOP_DENS_LOW
		|=> ##1 !ppFloppyLevel[`FOP_P_DENS])
		else $error("low density write late on outputs");

	// main scenarios
	swap_cov_c: cover property (modeWr && wrData[`FOP_SWAP_BIT]);
	tri_cov_c: cover property (triState_reg ##1 floppyPinOe == '0);
	dens_cov_c: cover property (dens_reg == FOP_DNS_LOW);
	pp_cov_c: cover property (pushPull_reg && !triState_reg);
	user_cov_c: cover property (dens_reg == FOP_DNS_USER);
endmodule
`default_nettype wire

// file: hdl/fop_consts.svh
`ifndef FOP_CONSTS_SVH
`define FOP_CONSTS_SVH

// register indices; byte address is four times the index
`define FOP_OPT_IDX      8'hF1
`define FOP_MODE_IDX     8'hF0
`define FOP_IDX_W        8
// reset values and readable bits
`define FOP_OPT_RST      8'h00
`define FOP_MODE_RST     8'h0C
`define FOP_OPT_MASK     8'h0C
`define FOP_MODE_MASK    8'hDC
// field positions
`define FOP_DENS_LSB     2
`define FOP_DENS_MSB     3
`define FOP_IFM_LSB      2
`define FOP_IFM_MSB      3
`define FOP_SWAP_BIT     4
`define FOP_TYPE_BIT     6
`define FOP_TRI_BIT      7
// field codes
`define FOP_DENS_NORM    2'h0
`define FOP_DENS_USER    2'h1
`define FOP_DENS_HIGH    2'h2
`define FOP_DENS_LOW     2'h3
`define FOP_IFM_M30      2'h0
`define FOP_IFM_ALT      2'h1
`define FOP_IFM_RSVD     2'h2
`define FOP_IFM_AT       2'h3
// floppy output vector layout
`define FOP_AUX_W        5
`define FOP_PIN_W        10
`define FOP_P_DENS       0
`define FOP_P_DS0        1
`define FOP_P_DS1        2
`define FOP_P_MOT0       3
`define FOP_P_MOT1       4
`define FOP_P_AUX        5
// bus encodings
`define FOP_HTRANS_NSEQ  2'h2
`define FOP_HSIZE_WORD   3'h2
`define FOP_ADDR_PAD     22'h000000
`define FOP_DATA_PAD     24'h000000

`endif

// file: hdl/fop_pkg.sv
`include "fop_consts.svh"
`default_nettype none
package fop_pkg;
	typedef enum logic [1:0]
	{
		FOP_DNS_NORM = `FOP_DENS_NORM,
		FOP_DNS_USER = `FOP_DENS_USER,
		FOP_DNS_HIGH = `FOP_DENS_HIGH,
		FOP_DNS_LOW  = `FOP_DENS_LOW
	} fop_dens_t;
	typedef enum logic [1:0]
	{
		FOP_MD_M30  = `FOP_IFM_M30,
		FOP_MD_ALT  = `FOP_IFM_ALT,
		FOP_MD_RSVD = `FOP_IFM_RSVD,
		FOP_MD_AT   = `FOP_IFM_AT
	} fop_ifmode_t;
endpackage
`default_nettype wire

// file: hdl/fop_ahb_slave.sv
`include "fop_consts.svh"
`default_nettype none
module fop_ahb_slave
	import fop_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// register file side
	output logic                       wrEn,
	output logic      [`FOP_IDX_W-1:0] wrIdx,
	output logic      [7:0]            wrData,
	input  wire logic [7:0]            rdOpt,
	input  wire logic [7:0]            rdMode
);
	logic                  addrTake;
	logic                  dpWrite_reg;
	logic [`FOP_IDX_W-1:0] dpIdx_reg;

	// true when the address matches a register word exactly
	function automatic logic hitIdx(input logic [31:0] a,
		input logic [`FOP_IDX_W-1:0] idx);
		hitIdx = (a == {`FOP_ADDR_PAD, idx, 2'h0});
	endfunction

	// readable value of one register, forwarding a write in flight
	function automatic logic [7:0] readVal(input logic [31:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (hitIdx(a, `FOP_OPT_IDX))
			v = (wrEn && wrIdx == `FOP_OPT_IDX) ?
				(wrData & `FOP_OPT_MASK) : rdOpt;
		else if (hitIdx(a, `FOP_MODE_IDX))
			v = (wrEn && wrIdx == `FOP_MODE_IDX) ?
				(wrData & `FOP_MODE_MASK) : rdMode;
		readVal = v;
	endfunction

	assign addrTake = hsel && hready && htrans == `FOP_HTRANS_NSEQ;
	assign wrEn     = dpWrite_reg;
	assign wrIdx    = dpIdx_reg;
	assign wrData   = hwdata[7:0];

	// write address phase; non-word writes are dropped
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			dpWrite_reg <= 1'b0;
			dpIdx_reg   <= `FOP_OPT_IDX;
		end
		else
		begin
			dpWrite_reg <= addrTake && hwrite &&
				hsize == `FOP_HSIZE_WORD &&
				(hitIdx(haddr, `FOP_OPT_IDX) ||
				hitIdx(haddr, `FOP_MODE_IDX));
			dpIdx_reg   <= haddr[`FOP_IDX_W+1:2];
		end

	// zero wait states, always OKAY; unmapped reads give zero
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else if (addrTake && !hwrite)
			hrdata <= {`FOP_DATA_PAD, readVal(haddr)};
endmodule
`default_nettype wire

// file: hdl/fop_pin_drive.sv
`include "fop_consts.svh"
`default_nettype none
module fop_pin_drive
	import fop_pkg::*;
#(
	parameter int W = `FOP_PIN_W
)
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// levels and driver setup
	input  wire logic [W-1:0] level,
	input  wire logic         pushPull,
	input  wire logic         triState,
	// pad controls
	output logic      [W-1:0] pinOut,
	output logic      [W-1:0] pinOe
);
	// open drain only pulls low; reset keeps pads released
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			pinOut <= '0;
			pinOe  <= '0;
		end
		else
		begin
			pinOut <= pushPull ? level : '0;
			if (triState)
				pinOe <= '0;
			else
				pinOe <= pushPull ? '1 : ~level;
		end
endmodule
`default_nettype wire

// file: bench/fop_tb.sv
`include "fop_consts.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// byte addresses are four times the register index
	localparam logic [31:0] OPT_ADDR   = {`FOP_ADDR_PAD, `FOP_OPT_IDX, 2'h0};
	localparam logic [31:0] MODE_ADDR  = {`FOP_ADDR_PAD, `FOP_MODE_IDX, 2'h0};
	localparam logic [31:0] UNMAP_ADDR = 32'h000003C8;
	// core input patterns: aux, motor 1/0, drive 1/0, density
	localparam logic [9:0] PATS [4] = '{10'h00A, 10'h015, 10'h3E0, 10'h2B3};
	// option and mode pairs, chosen to hit every field code
	localparam logic [15:0] CASES [9] = '{16'h000C, 16'h040C, 16'h080C,
		16'h0C0C, 16'h0010, 16'h0814, 16'h0C48, 16'h04DC, 16'h088C};

	logic        clk_sys;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [9:0]  coreIn;
	logic [9:0]  floppyPinOut;
	logic [9:0]  floppyPinOe;
	logic [9:0]  ppFloppyLevel;
	logic [1:0]  ifModeSel;
	logic [31:0] rdVal;
	int          errCount;
	int          checksDone;

	fop_top dut
	(
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.hsel          (hsel),
		.haddr         (haddr),
		.htrans        (htrans),
		.hwrite        (hwrite),
		.hsize         (hsize),
		.hready        (hreadyout),
		.hwdata        (hwdata),
		.hrdata        (hrdata),
		.hreadyout     (hreadyout),
		.hresp         (hresp),
		.densNormal    (coreIn[0]),
		.driveSel0     (coreIn[1]),
		.driveSel1     (coreIn[2]),
		.motorEn0      (coreIn[3]),
		.motorEn1      (coreIn[4]),
		.auxOut        (coreIn[9:5]),
		.floppyPinOut  (floppyPinOut),
		.floppyPinOe   (floppyPinOe),
		.ppFloppyLevel (ppFloppyLevel),
		.ifModeSel     (ifModeSel)
	);

	// free-running system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checksDone++;
		if (seen !== exp)
		begin
			errCount++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask

	// bounded wait for hready sampled high at a rising edge
	task automatic waitReady();
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			errCount++;
			$display("MISMATCH at %0t: bus wait timed out", $time);
			reportAndStop();
		end
	endtask

	// one single word transfer: address phase, then data phase
	task automatic busXfer(input logic wr, input logic [31:0] addr,
		input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= wr;
		hsize <= `FOP_HSIZE_WORD;
		htrans <= `FOP_HTRANS_NSEQ;
		waitReady();
		htrans <= 2'h0;
		hwdata <= wdata;
		waitReady();
		rdata = hrdata;
		check({31'h0, hresp}, 32'h0, "response code");
	endtask

	task automatic regRead(input logic [31:0] addr, input logic [31:0] exp,
		input string what);
		busXfer(1'b0, addr, 32'h0, rdVal);
		check(rdVal, exp, what);
	endtask

	// expected pad levels worked out from the config fields
	function automatic logic [9:0] expLevel(logic [9:0] i, logic [7:0] o,
		logic [7:0] m);
		logic [9:0] v;
		v = i;
		if (o[3:2] == 2'h2) v[0] = 1'b1;
		if (o[3:2] == 2'h3) v[0] = 1'b0;
		if (m[4])
		begin
			v[2:1] = {i[1], i[2]};
			v[4:3] = {i[3], i[4]};
		end
		return v;
	endfunction

	// drive each pattern, then look one edge later
	task automatic checkPads(input logic [7:0] o, input logic [7:0] m);
		logic [9:0] e;
		logic [9:0] ne;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk_sys);
			coreIn <= PATS[k];
			@(posedge clk_sys);
			#1;
			e = expLevel(PATS[k], o, m);
			ne = ~e;
			check(32'(ppFloppyLevel), 32'(e), "parallel levels");
			check(32'(ifModeSel), 32'(m[3:2]), "interface mode");
			if (m[7])
				check(32'(floppyPinOe), 32'h0, "tri-state enable");
			else if (m[6])
			begin
				check(32'(floppyPinOut), 32'(e), "push-pull out");
				check(32'(floppyPinOe), 32'h3FF, "push-pull oe");
			end
			else
			begin
				check(32'(floppyPinOut), 32'h0, "open drain out");
				check(32'(floppyPinOe), 32'(ne), "open drain oe");
			end
		end
	endtask

	// reserved bits are always written as zero
	task automatic setCfg(input logic [7:0] o, input logic [7:0] m);
		busXfer(1'b1, OPT_ADDR, {24'h0, o}, rdVal);
		busXfer(1'b1, MODE_ADDR, {24'h0, m}, rdVal);
		regRead(OPT_ADDR, {24'h0, o & `FOP_OPT_MASK}, "option rd");
		regRead(MODE_ADDR, {24'h0, m & `FOP_MODE_MASK}, "mode rd");
		checkPads(o, m);
	endtask

	// main sequence
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		coreIn = 10'h000;
		errCount = 0;
		checksDone = 0;
		repeat (4) @(posedge clk_sys);
		#1;
		check(32'(ifModeSel), 32'h3, "mode in reset");
		@(posedge clk_sys);
		rst_n <= 1'b1;
		regRead(OPT_ADDR, 32'h0, "option reset");
		regRead(MODE_ADDR, 32'h0000000C, "mode reset");
		checkPads(8'h00, 8'h0C);
		foreach (CASES[k])
			setCfg(CASES[k][15:8], CASES[k][7:0]);
		// stray access must neither store nor alias
		busXfer(1'b1, UNMAP_ADDR, 32'h000000FF, rdVal);
		regRead(UNMAP_ADDR, 32'h0, "unmapped read");
		regRead(OPT_ADDR, 32'h00000008, "option kept");
		// second reset in mid-run
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		#1;
		check(32'(floppyPinOe), 32'h0, "oe in reset");
		check(32'(floppyPinOut), 32'h0, "pad out in reset");
		check(32'(ppFloppyLevel), 32'h0, "pp level in reset");
		check(32'(ifModeSel), 32'h3, "mode in reset");
		@(posedge clk_sys);
		rst_n <= 1'b1;
		regRead(OPT_ADDR, 32'h0, "option re-reset");
		regRead(MODE_ADDR, 32'h0000000C, "mode re-reset");
		checkPads(8'h00, 8'h0C);
		reportAndStop();
	end
endmodule
`default_nettype wire
